/* File: bench/tb_tts_sequencer.sv */
// Self-checking bench of the top-off/trickle sequencer.
// Assumes the stage model on the far side, one 50 MHz clock.
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_tts_sequencer;
    import tts_pkg::*;
    localparam int SEC = 64;
    localparam int TOP = 4;
    localparam int TRK = 10;
    logic        clk, srst, psel, penable, pwrite, fast_done, cap_sel, new_cycle, sleep, fsmp;
    logic        pready, pslverr, irq, er, sw, lamp, tpin, cold, hot, cut, mcv, capl;
    logic [7:0]  paddr;
    logic [1:0]  temp;
    logic [31:0] pwdata, prdata, rd, mcv_at, charge;
    int          err_count, check_count, pulses, edges;
    // --------------------------------------------
    // Instances
    // --------------------------------------------
    tts_sequencer #(.SEC_CYCLES(SEC), .TOPOFF_CYCLES(TOP)) dut (
        .core_clk_i(clk), .srst_i(srst), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .fast_done_i(fast_done), .fast_drive_i(1'b0),
        .fast_sample_i(fsmp), .timing_capacitor_large_i(capl), .cold_threshold_i(cold),
        .hot_threshold_i(hot), .cutoff_threshold_i(cut), .max_cell_voltage_limit_i(mcv),
        .new_cycle_i(new_cycle), .sleep_i(sleep), .charge_switch_out_o(sw),
        .status_lamp_o(lamp), .timer_pin_o(tpin));
    tts_stage_model model (
        .core_clk_i(clk), .srst_i(srst), .charge_switch_out_i(sw), .temp_i(temp),
        .cap_sel_i(cap_sel), .mcv_at_i(mcv_at), .cold_o(cold), .hot_o(hot), .cutoff_o(cut),
        .mcv_o(mcv), .cap_large_o(capl), .charge_o(charge));
    always #10 clk = ~clk;
    // --------------------------------------------
    // Shared tasks
    // --------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_state(input logic [7:0] e);
        int n;
        n = 0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        while (rd[7:0] !== e && n < 400)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        `CHK("state", e, rd[7:0])
    endtask
    task automatic sec(input int p, input int e);
        logic last;
        pulses = 0;
        edges  = 0;
        last   = tpin;
        repeat (SEC)
        begin
            @(posedge clk);
            if (sw === 1'b1)
                pulses++;
            if (tpin !== last)
                edges++;
            last = tpin;
        end
        `CHK("pulse cycles", p, pulses)
        `CHK("timer pin edges", e, edges)
        `CHK("lamp", 1'b0, lamp)
    endtask
    task automatic start(input logic c);
        cap_sel   <= c;
        fast_done <= 1'b1;
        @(posedge clk);
        fast_done <= 1'b0;
    endtask
    task automatic restart();
        new_cycle <= 1'b1;
        @(posedge clk);
        new_cycle <= 1'b0;
        wait_state(ST_FAST);
    endtask
    task automatic settle(input logic [1:0] t);
        temp <= t;
        repeat (4) @(posedge clk);
    endtask
    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task automatic t_regs();
        wait_state(ST_FAST);
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        apb(1'b1, ADDR_TRKW, TRK);
        apb(1'b1, ADDR_LIMIT, 32'h8);
    endtask
    task automatic t_topoff();
        logic [15:0] held;
        start(1'b1);
        wait_state(ST_TOPOFF);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, ADDR_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        sec(SEC / 16, 1);
        settle(2'h1);
        wait_state(ST_TCOLD);
        held = rd[31:16];
        sec(TRK, 0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("paused timer", held, rd[31:16])
        settle(2'h0);
        wait_state(ST_TOPOFF);
        settle(2'h2);
        wait_state(ST_THOT);
        sec(0, 1);
        settle(2'h0);
        wait_state(ST_TOPOFF);
        wait_state(ST_TRICKLE);
    endtask
    task automatic t_trickle();
        sec(TRK, 0);
        settle(2'h2);
        sec(0, 0);
        settle(2'h0);
        sec(TRK, 0);
        mcv_at <= charge + 32'h1;
        wait_state(ST_DONE);
        mcv_at <= 32'hffffffff;
        sec(0, 0);
        restart();
    endtask
    task automatic t_cutoff();
        start(1'b1);
        wait_state(ST_TOPOFF);
        settle(2'h3);
        wait_state(ST_CUTOFF);
        sec(0, 0);
        settle(2'h0);
        wait_state(ST_TRICKLE);
        restart();
        start(1'b0);
        wait_state(ST_TRICKLE);
        sleep <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("timer pin", 1'b0, tpin)
        sleep <= 1'b0;
        wait_state(ST_FAST);
        `CHK("lamp in fast", 1'b1, lamp)
        fsmp <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("sampling pin", 1'b0, tpin)
        fsmp <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("pin after sampling", 1'b1, tpin)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(20 * 40000);
        err_count++;
        stop_test();
    end
    initial
    begin
        {clk, psel, penable, pwrite, fast_done, cap_sel, new_cycle, sleep, fsmp} = 9'h000;
        {srst, paddr, temp, pwdata, mcv_at} = {1'b1, 8'h00, 2'h0, 32'h0, 32'hffffffff};
        err_count   = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_topoff();
        t_trickle();
        t_cutoff();
        stop_test();
    end
endmodule

/* File: bench/tts_stage_model.sv */
// Partner model: power stage and threshold comparators.
// Assumes the bench sets temperature and capacitor choice.
`timescale 1ns/100ps
module tts_stage_model (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        charge_switch_out_i,
    input  wire logic [1:0]  temp_i,
    input  wire logic        cap_sel_i,
    input  wire logic [31:0] mcv_at_i,
    output logic             cold_o,
    output logic             hot_o,
    output logic             cutoff_o,
    output logic             mcv_o,
    output logic             cap_large_o,
    output logic [31:0]      charge_o
);
    // --------------------------------------------
    // Stage and comparators
    // --------------------------------------------
    // Current while high
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            charge_o <= 32'h0;
        else if (charge_switch_out_i)
            charge_o <= charge_o + 32'h1;
    end
    always_ff @(posedge core_clk_i)
    begin
        cold_o   <= (temp_i == 2'h1);
        hot_o    <= temp_i[1];
        cutoff_o <= (temp_i == 2'h3);
        mcv_o    <= (charge_o >= mcv_at_i);
    end
    assign cap_large_o = cap_sel_i;
endmodule

/* File: hw/tts_charge_timer.sv */
// Charge timer counting whole seconds up to a limit.
// Assumes the time base bundle supplies the second tick.
`timescale 1ns/100ps
module tts_charge_timer (
    input  wire logic                      core_clk_i,
    input  wire logic                      srst_i,
    tts_time_if.user                       tb,
    input  wire logic                      clr_i,
    input  wire logic                      run_i,
    input  wire logic [tts_pkg::TMR_W-1:0] limit_i,
    output logic      [tts_pkg::TMR_W-1:0] cnt_o,
    output logic                           expired_o
);
    import tts_pkg::*;

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;

    // ------------------------------------------------------------
    // Second counter
    // ------------------------------------------------------------
    assign cnt_o     = cnt_q;
    assign expired_o = (cnt_q >= limit_i);

    always_comb
    begin
        cnt_d = cnt_q;
        if (tb.ce && clr_i)
            cnt_d = '0;
        else if (run_i && tb.sec_tick && !expired_o)
            cnt_d = cnt_q + 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule

/* File: hw/tts_pkg.sv */
// Constants, register map and state codes of the top-off/trickle sequencer.
// Assumes a 50 MHz core clock and an APB master with 32-bit data.
package tts_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int PULSE_PERIOD_MS = 1000;
    localparam int SEC_CYCLES      = CLK_HZ / 1000 * PULSE_PERIOD_MS;
    localparam int TOPOFF_PULSE_US = 62500;
    localparam int TOPOFF_CYCLES   = int'(longint'(CLK_HZ) * TOPOFF_PULSE_US / 1_000_000);
    localparam int PHASE_W         = 26;
    localparam int TMR_W           = 16;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_TRKW     = 8'h04;
    localparam logic [7:0] ADDR_LIMIT    = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;

    localparam int               CTRL_TOPOFF_EN = 0;
    localparam logic             CTRL_RST       = 1'b1;
    localparam logic [PHASE_W-1:0] TRKW_RST     = PHASE_W'(TOPOFF_CYCLES);
    localparam logic [TMR_W-1:0] LIMIT_RST      = 16'h0a8c;
    localparam int               STATUS_CNT_LSB = 16;

    localparam int IRQ_W       = 4;
    localparam int IRQ_TOPOFF  = 0;
    localparam int IRQ_TRICKLE = 1;
    localparam int IRQ_DONE    = 2;
    localparam int IRQ_FAULT   = 3;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_FAST    = 8'h01,
        ST_EVAL    = 8'h02,
        ST_TOPOFF  = 8'h04,
        ST_TCOLD   = 8'h08,
        ST_THOT    = 8'h10,
        ST_CUTOFF  = 8'h20,
        ST_TRICKLE = 8'h40,
        ST_DONE    = 8'h80
    } tts_state_type;

endpackage

/* File: hw/tts_sec_base.sv */
// One-second phase counter with a tick at each wrap.
// Assumes a synchronous active-high reset.
`timescale 1ns/100ps
module tts_sec_base #(
    parameter int SEC_CYCLES = tts_pkg::SEC_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    tts_time_if.base  tb
);
    import tts_pkg::*;

    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] phase_d;
    logic               wrap;

    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    assign wrap        = (phase_q == PHASE_W'(SEC_CYCLES - 1));
    assign tb.sec_tick = wrap & tb.ce;
    assign tb.phase    = phase_q;

    always_comb
    begin
        phase_d = phase_q;
        if (tb.ce)
        begin
            phase_d = wrap ? '0 : phase_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            phase_q <= '0;
        else
            phase_q <= phase_d;
    end
endmodule

/* File: hw/tts_sequencer.sv */
// Post-fast-charge sequencer: top-off, pulse trickle, faults, APB registers.
// Assumes threshold inputs are synchronous to core_clk_i and APB is on the same clock.
`timescale 1ns/100ps
// What this block does
// - After fast charge, evaluate capacitor then branch
// - Top-off resets timer; ends on expiry/fault
// - Top-off pulse 62.5 ms each second
// - Lamp off in top-off and trickle
// - Cold pauses timer, trickles, then resumes top-off
// - Hot stops charge, timer runs, then branch
// - Cutoff stops charge; only trickle resumes
// - Trickle pulse each second, programmable width
// - Timer runs in top-off, idle in trickle
// - Timer pin low in sleep, sampling dips
// - Timer pin steady unless timer counts
// - Max cell voltage ends charging until a new cycle
// - Hot suspends trickle pulses until cleared
// - Trickle continues with no time limit
// - New cycle on power, battery, sleep exit
// - Switch high passes current, low cuts
module tts_sequencer #(
    parameter int SEC_CYCLES    = tts_pkg::SEC_CYCLES,
    parameter int TOPOFF_CYCLES = tts_pkg::TOPOFF_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    input  wire logic        fast_done_i,
    input  wire logic        fast_drive_i,
    input  wire logic        fast_sample_i,
    input  wire logic        timing_capacitor_large_i,
    input  wire logic        cold_threshold_i,
    input  wire logic        hot_threshold_i,
    input  wire logic        cutoff_threshold_i,
    input  wire logic        max_cell_voltage_limit_i,
    input  wire logic        new_cycle_i,
    input  wire logic        sleep_i,
    output logic             charge_switch_out_o,
    output logic             status_lamp_o,
    output logic             timer_pin_o
);
    import tts_pkg::*;

    tts_time_if tb ();

    tts_state_type      state_q, state_d;
    logic               sleep_q, sleep_d;
    logic               sw_q, sw_d;
    logic               lamp_q, lamp_d;
    logic               pin_q, pin_d;
    logic               topoff_en_q, topoff_en_d;
    logic [PHASE_W-1:0] trkw_q, trkw_d;
    logic [TMR_W-1:0]   limit_q, limit_d;
    logic [IRQ_W-1:0]   ist_q, ist_d;
    logic [IRQ_W-1:0]   ien_q, ien_d;
    logic               irq_q, irq_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               rdy_q, rdy_d;
    logic               err_q, err_d;
    logic [IRQ_W-1:0]   ev;
    logic               restart;
    logic               tmr_clr;
    logic               tmr_run;
    logic               tmr_exp;
    logic [TMR_W-1:0]   tmr_cnt;
    logic               wr_acc;
    logic               top_pulse;
    logic               trk_pulse;

    // ------------------------------------------------------------
    // Time base and charge timer
    // ------------------------------------------------------------
    assign tb.ce = ce_i;

    tts_sec_base #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_base (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .tb         (tb)
    );

    assign tmr_run = (state_q == ST_TOPOFF) || (state_q == ST_THOT);
    assign tmr_clr = (state_q == ST_EVAL);

    tts_charge_timer u_timer (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .tb         (tb),
        .clr_i      (tmr_clr),
        .run_i      (tmr_run),
        .limit_i    (limit_q),
        .cnt_o      (tmr_cnt),
        .expired_o  (tmr_exp)
    );

    assign top_pulse = (tb.phase < PHASE_W'(TOPOFF_CYCLES));
    assign trk_pulse = (tb.phase < trkw_q);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // new cycle start
    assign restart = new_cycle_i || (sleep_q && !sleep_i);

    always_comb
    begin
        state_d = state_q;
        ev      = '0;
        case (state_q)
            ST_FAST:
            begin
                if (fast_done_i)
                    state_d = ST_EVAL;
            end
            ST_EVAL:
            begin
                if (timing_capacitor_large_i && topoff_en_q)
                    state_d = ST_TOPOFF;
                else
                    state_d = ST_TRICKLE;
            end
            ST_TOPOFF:
            begin
                if (max_cell_voltage_limit_i)
                    state_d = ST_DONE;
                else if (cutoff_threshold_i)
                    state_d = ST_CUTOFF;
                else if (hot_threshold_i)
                    state_d = ST_THOT;
                else if (cold_threshold_i)
                    state_d = ST_TCOLD;
                else if (tmr_exp)
                    state_d = ST_TRICKLE;
            end
            ST_TCOLD:
            begin
                if (max_cell_voltage_limit_i)
                    state_d = ST_DONE;
                else if (cutoff_threshold_i)
                    state_d = ST_CUTOFF;
                else if (hot_threshold_i)
                    state_d = ST_THOT;
                else if (!cold_threshold_i)
                    state_d = ST_TOPOFF;
            end
            ST_THOT:
            begin
                if (max_cell_voltage_limit_i)
                    state_d = ST_DONE;
                else if (cutoff_threshold_i)
                    state_d = ST_CUTOFF;
                else if (!hot_threshold_i)
                    state_d = tmr_exp ? ST_TRICKLE : ST_TOPOFF;
            end
            ST_CUTOFF:
            begin
                if (max_cell_voltage_limit_i)
                    state_d = ST_DONE;
                else if (!hot_threshold_i && !cutoff_threshold_i)
                    state_d = ST_TRICKLE;
            end
            ST_TRICKLE:
            begin
                if (max_cell_voltage_limit_i)
                    state_d = ST_DONE;
            end
            ST_DONE:
            begin
                state_d = ST_DONE;
            end
            default:
            begin
                state_d = ST_FAST;
            end
        endcase
        if (restart)
            state_d = ST_FAST;
        if (!ce_i)
            state_d = state_q;
        if (state_d != state_q)
        begin
            ev[IRQ_TOPOFF]  = (state_d == ST_TOPOFF);
            ev[IRQ_TRICKLE] = (state_d == ST_TRICKLE);
            ev[IRQ_DONE]    = (state_d == ST_DONE);
            ev[IRQ_FAULT]   = (state_d == ST_TCOLD) || (state_d == ST_THOT) || (state_d == ST_CUTOFF);
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    always_comb
    begin
        sleep_d = ce_i ? sleep_i : sleep_q;
        sw_d    = 1'b0;
        lamp_d  = 1'b0;
        pin_d   = 1'b1;
        case (state_q)
            ST_FAST:    sw_d = fast_drive_i;
            ST_TOPOFF:  sw_d = top_pulse;
            ST_TCOLD:   sw_d = trk_pulse;
            ST_TRICKLE: sw_d = trk_pulse && !hot_threshold_i && !cutoff_threshold_i;
            default:    sw_d = 1'b0;
        endcase
        if (sleep_i)
            sw_d = 1'b0;
        lamp_d = (state_q == ST_FAST) && !sleep_i;
        if (tmr_run && !tmr_exp)
            pin_d = tb.sec_tick ? !pin_q : pin_q;
        if (sleep_i || ((state_q == ST_FAST) && fast_sample_i))
            pin_d = 1'b0;
        if (!ce_i)
        begin
            sw_d   = sw_q;
            lamp_d = lamp_q;
            pin_d  = pin_q;
        end
    end

    // ------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------
    assign wr_acc = psel_i && penable_i && rdy_q && pwrite_i && ce_i;

    always_comb
    begin
        topoff_en_d = topoff_en_q;
        trkw_d      = trkw_q;
        limit_d     = limit_q;
        ien_d       = ien_q;
        ist_d       = ist_q | ev;
        rdata_d     = rdata_q;
        rdy_d       = 1'b0;
        err_d       = 1'b0;
        if (wr_acc)
        begin
            if (paddr_i == ADDR_CTRL)
                topoff_en_d = pwdata_i[CTRL_TOPOFF_EN];
            else if (paddr_i == ADDR_TRKW)
                trkw_d = pwdata_i[PHASE_W-1:0];
            else if (paddr_i == ADDR_LIMIT)
                limit_d = pwdata_i[TMR_W-1:0];
            else if (paddr_i == ADDR_IRQ_CLR)
                ist_d = (ist_q & ~pwdata_i[IRQ_W-1:0]) | ev;
            else if (paddr_i == ADDR_IRQ_EN)
                ien_d = pwdata_i[IRQ_W-1:0];
        end
        if (psel_i && !penable_i)
        begin
            rdy_d   = 1'b1;
            rdata_d = '0;
            if (paddr_i == ADDR_CTRL)
                rdata_d[CTRL_TOPOFF_EN] = topoff_en_q;
            else if (paddr_i == ADDR_TRKW)
                rdata_d[PHASE_W-1:0] = trkw_q;
            else if (paddr_i == ADDR_LIMIT)
                rdata_d[TMR_W-1:0] = limit_q;
            else if (paddr_i == ADDR_STATUS)
                rdata_d = {tmr_cnt, 8'h00, state_q};
            else if (paddr_i == ADDR_IRQ_STAT)
                rdata_d[IRQ_W-1:0] = ist_q;
            else if (paddr_i == ADDR_IRQ_EN)
                rdata_d[IRQ_W-1:0] = ien_q;
            else if (paddr_i != ADDR_IRQ_CLR)
                err_d = 1'b1;
        end
        if (!ce_i)
        begin
            ist_d   = ist_q;
            rdata_d = rdata_q;
            rdy_d   = rdy_q;
            err_d   = err_q;
        end
        irq_d = ce_i ? |(ist_q & ien_q) : irq_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            state_q     <= ST_FAST;
            sleep_q     <= 1'b0;
            sw_q        <= 1'b0;
            lamp_q      <= 1'b0;
            pin_q       <= 1'b1;
            topoff_en_q <= CTRL_RST;
            trkw_q      <= TRKW_RST;
            limit_q     <= LIMIT_RST;
            ist_q       <= '0;
            ien_q       <= '0;
            irq_q       <= 1'b0;
            rdata_q     <= '0;
            rdy_q       <= 1'b0;
            err_q       <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            sleep_q     <= sleep_d;
            sw_q        <= sw_d;
            lamp_q      <= lamp_d;
            pin_q       <= pin_d;
            topoff_en_q <= topoff_en_d;
            trkw_q      <= trkw_d;
            limit_q     <= limit_d;
            ist_q       <= ist_d;
            ien_q       <= ien_d;
            irq_q       <= irq_d;
            rdata_q     <= rdata_d;
            rdy_q       <= rdy_d;
            err_q       <= err_d;
        end
    end

    assign charge_switch_out_o = sw_q;
    assign status_lamp_o       = lamp_q;
    assign timer_pin_o         = pin_q;
    assign irq_o               = irq_q;
    assign prdata_o            = rdata_q;
    assign pready_o            = rdy_q;
    assign pslverr_o           = err_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_quiet;
        ce_i && !restart;
    endsequence

    sequence s_mcv_hit;
        s_quiet ##0 max_cell_voltage_limit_i && (state_q inside {ST_TOPOFF, ST_TCOLD, ST_THOT, ST_TRICKLE});
    endsequence

    a_fast_to_eval: assert property (s_quiet ##0 (state_q == ST_FAST) && fast_done_i |=>
        state_q == ST_EVAL ##1 state_q inside {ST_TOPOFF, ST_TRICKLE, ST_FAST})
        else $error("fast end did not branch");
    a_eval_clear: assert property (
        s_quiet ##0 (state_q == ST_EVAL) && timing_capacitor_large_i && topoff_en_q
        |=> (state_q == ST_TOPOFF) && (tmr_cnt == 0)) else $error("top-off entry without timer reset");
    a_topoff_width: assert property (
        s_quiet ##0 (state_q == ST_TOPOFF) && !sleep_i && ((tb.phase == 0) || (tb.phase == PHASE_W'(TOPOFF_CYCLES)))
        |=> charge_switch_out_o == ($past(tb.phase) == 0)) else $error("top-off pulse width wrong");
    a_lamp_off: assert property (ce_i && !(state_q inside {ST_FAST}) |=> !status_lamp_o)
        else $error("lamp lit outside fast charge");
    a_cold_pause: assert property (ce_i && (state_q == ST_TCOLD) |=> $stable(tmr_cnt))
        else $error("timer moved during cold pause");
    a_hot_off: assert property (ce_i && (state_q inside {ST_THOT, ST_CUTOFF}) |=> !charge_switch_out_o)
        else $error("charge during hot fault");
    a_cutoff_trk: assert property (
        s_quiet ##0 (state_q == ST_CUTOFF) && !hot_threshold_i && !cutoff_threshold_i && !max_cell_voltage_limit_i
        |=> state_q == ST_TRICKLE) else $error("cutoff did not resume trickle");
    a_mcv_done: assert property (
        s_mcv_hit |=> (state_q == ST_DONE) ##1 (state_q == ST_DONE) || $past(restart))
        else $error("max cell voltage did not end charge");
    a_trk_hot: assert property (ce_i && (state_q == ST_TRICKLE) && hot_threshold_i |=> !charge_switch_out_o)
        else $error("trickle pulse during hot fault");
    a_sleep_pin: assert property (ce_i && sleep_i |=> !timer_pin_o && !charge_switch_out_o)
        else $error("timer pin not low in sleep");
    a_pin_steady: assert property (ce_i && (!tmr_run || tmr_exp) && !sleep_i && !fast_sample_i |=> timer_pin_o)
        else $error("timer pin moved while timer idle");
endmodule

/* File: hw/tts_time_if.sv */
// Time base bundle shared by the sequencer and its helpers.
// Assumes one clock; the top drives the clock enable.
`timescale 1ns/100ps
interface tts_time_if;
    import tts_pkg::*;
    logic               ce;
    logic               sec_tick;
    logic [PHASE_W-1:0] phase;

    modport base (input ce, output sec_tick, output phase);
    modport user (input ce, input sec_tick, input phase);
endinterface
